/* rtl/group_current_scale.sv */
// Scales one colour group: max_current * (level + 1) / 256
module group_current_scale
  import matrix_cfg_pkg::*;
#(
  parameter int cur_w = 16
)
(
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // Inputs
  input  wire logic [cur_w-1:0]   max_channel_current,
  input  wire logic [level_w-1:0] level,
  // Output
  output logic      [cur_w-1:0]   group_current
);

  // Full width product avoids overflow before the divide
  wire [cur_w+level_w:0] product = max_channel_current * ({1'b0, level} + 9'h001);

  // Registered result
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      group_current <= '0;
    else
      group_current <= product[cur_w+level_w-1:level_w];
  end

endmodule

/* rtl/matrix_cfg_pkg.sv */
package matrix_cfg_pkg;

  // Register byte offsets on the APB
  localparam logic [7:0] layout_off  = 8'h00;
  localparam logic [7:0] gain_off    = 8'h04;
  localparam logic [7:0] red_off     = 8'h08;
  localparam logic [7:0] green_off   = 8'h0c;
  localparam logic [7:0] blue_off    = 8'h10;
  localparam logic [7:0] scan_off    = 8'h14;
  localparam logic [7:0] current_off = 8'h18;

  // Field widths and reset values
  localparam int          lines_per_dev = 16;
  localparam int          line_w        = 4;
  localparam int          level_w       = 8;
  localparam int          code_w        = 3;
  localparam logic [7:0]  level_rst     = 8'h7f;
  localparam logic [2:0]  gain_rst      = 3'h0;
  localparam logic [2:0]  layout_rst    = 3'h0;
  localparam logic [1:0]  pos_rst       = 2'h0;

  // Layout codes
  localparam logic [2:0] lay_indep   = 3'h0;
  localparam logic [2:0] lay_s2      = 3'h1;
  localparam logic [2:0] lay_s3a     = 3'h2;
  localparam logic [2:0] lay_s3b     = 3'h3;
  localparam logic [2:0] lay_s3c     = 3'h4;
  localparam logic [2:0] lay_s3d     = 3'h5;
  localparam logic [2:0] lay_s4a     = 3'h6;
  localparam logic [2:0] lay_s4b     = 3'h7;

  // Global current gain, scaled by 100
  localparam logic [14:0] gain_x100 [8] = '{15'd2417, 15'd3057, 15'd4949, 15'd8661,
                                            15'd10394, 15'd12992, 15'd14848, 15'd17323};

  // Control register fields
  typedef struct packed {
    logic [2:0] matrix_layout_select;
    logic       line_order_reverse;
    logic [1:0] stack_position;
    logic [1:0] last_line_cut;
    logic       scan_enable;
  } layout_cfg_s;

  // Current setting bundle
  typedef struct packed {
    logic [2:0] global_gain_code;
    logic [7:0] red_group_level;
    logic [7:0] green_group_level;
    logic [7:0] blue_group_level;
  } current_cfg_s;

endpackage

/* rtl/matrix_scan_and_current_config.sv */
// Overview of operation
// - Codes 000b independent, 001b two-device stack
// - Higher codes pick stack size and order
// - Two-stack: device one lines 1-16, two 17-32
// - Reverse bit steps line switches descending
// - One 3-bit gain scales all channels
// - Gain codes map 24.17 up to 173.23
// - Separate 8-bit level per colour group
// - Group current is max times (code+1)/256
// - Up to four devices share line switches
module matrix_scan_and_current_config
  import matrix_cfg_pkg::*;
#(
  parameter int cur_w = 16
)
(
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Scan step from the line timer
  input  wire logic               line_step,
  // Line switch drive
  output logic [lines_per_dev-1:0] line_switch,
  output logic                     stack_line_active,
  output logic [5:0]               global_line,
  // Current setting
  output logic [14:0]              global_current_gain,
  output logic [cur_w-1:0]         red_current,
  output logic [cur_w-1:0]         green_current,
  output logic [cur_w-1:0]         blue_current
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  layout_cfg_s  lay_reg;
  current_cfg_s cur_reg;
  logic [cur_w-1:0] max_cur_reg;

  // Access decode
  wire wr_en  = psel && penable && pwrite;
  wire rd_acc = psel && penable && !pwrite;
  wire hit_lay = (paddr == layout_off);
  wire hit_gain = (paddr == gain_off);
  wire hit_red = (paddr == red_off);
  wire hit_grn = (paddr == green_off);
  wire hit_blu = (paddr == blue_off);
  wire hit_scan = (paddr == scan_off);
  wire hit_cur = (paddr == current_off);
  wire hit_any = hit_lay || hit_gain || hit_red || hit_grn || hit_blu || hit_scan || hit_cur;

  // Zero wait state slave
  assign pready  = 1'b1;
  assign pslverr = (wr_en || rd_acc) && !hit_any;

  // Configuration writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lay_reg <= '{layout_rst, 1'b0, pos_rst, 2'h0, 1'b0};
      cur_reg <= '{gain_rst, level_rst, level_rst, level_rst};
      max_cur_reg <= '0;
    end
    else if (wr_en)
    begin
      if (hit_lay)
        lay_reg <= pwdata[8:0];
      if (hit_gain)
        cur_reg.global_gain_code <= pwdata[code_w-1:0];
      if (hit_red)
        cur_reg.red_group_level <= pwdata[level_w-1:0];
      if (hit_grn)
        cur_reg.green_group_level <= pwdata[level_w-1:0];
      if (hit_blu)
        cur_reg.blue_group_level <= pwdata[level_w-1:0];
      if (hit_cur)
        max_cur_reg <= pwdata[cur_w-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stack geometry

  // Devices in the stack for each layout code
  logic [2:0] dev_count;
  always_comb
  begin
    case (lay_reg.matrix_layout_select)
      lay_indep: dev_count = 3'h1;
      lay_s2: dev_count = 3'h2;
      lay_s3a, lay_s3b, lay_s3c, lay_s3d: dev_count = 3'h3;
      default: dev_count = 3'h4;
    endcase
  end

  // Slot of this device in the scan order, from its physical position
  logic [1:0] scan_slot;
  always_comb
  begin
    scan_slot = lay_reg.stack_position;
    if ((lay_reg.matrix_layout_select == lay_s3b) || (lay_reg.matrix_layout_select == lay_s3d))
    begin
      // Order one, three, two
      case (lay_reg.stack_position)
        2'h1: scan_slot = 2'h2;
        2'h2: scan_slot = 2'h1;
        default: scan_slot = lay_reg.stack_position;
      endcase
    end
    else if (lay_reg.matrix_layout_select == lay_s4b)
    begin
      // Order one, four, two, three
      case (lay_reg.stack_position)
        2'h1: scan_slot = 2'h2;
        2'h2: scan_slot = 2'h3;
        2'h3: scan_slot = 2'h1;
        default: scan_slot = 2'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scan sequencer

  // Unused switches are the top ones, or the bottom ones when reversed; software sets how many to skip
  wire [line_w-1:0] last_step = line_w'(lines_per_dev - 1) - {2'h0, lay_reg.last_line_cut};

  logic [line_w-1:0] step_reg;   // Step within this device
  logic [1:0]        slot_reg;   // Which device of the stack scans now
  wire               stack_mode = (lay_reg.matrix_layout_select != lay_indep);
  wire               step_wrap  = (step_reg == last_step);
  wire [1:0]         last_slot  = 2'(dev_count - 3'h1);

  // Shared scan position across the stack
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      step_reg <= '0;
      slot_reg <= '0;
    end
    else if (wr_en && hit_lay)
    begin
      step_reg <= '0;
      slot_reg <= '0;
    end
    else if (lay_reg.scan_enable && line_step)
    begin
      step_reg <= step_wrap ? '0 : step_reg + 4'h1;
      if (step_wrap)
        slot_reg <= (slot_reg == last_slot || !stack_mode) ? 2'h0 : slot_reg + 2'h1;
    end
  end

  // This device owns the current line when its slot is scanning
  wire own_turn = !stack_mode || (slot_reg == scan_slot);
  // Reverse mapping lets a rotated device keep the global order
  wire [line_w-1:0] phys_line = lay_reg.line_order_reverse ?
                                line_w'(lines_per_dev - 1) - step_reg : step_reg;

  // One-hot line switch drive, one generate entry per switch
  logic [lines_per_dev-1:0] ls_next;
  for (genvar i = 0; i < lines_per_dev; i++)
  begin : g_ls
    assign ls_next[i] = lay_reg.scan_enable && own_turn && (phys_line == line_w'(i));
  end

  // Registered pin drive
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line_switch <= '0;
      stack_line_active <= 1'b0;
      global_line <= '0;
    end
    else
    begin
      line_switch <= ls_next;
      stack_line_active <= lay_reg.scan_enable && own_turn;
      global_line <= {slot_reg, step_reg};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Current setting

  // Gain lookup registered to keep outputs flop based
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      global_current_gain <= '0;
    else
      global_current_gain <= gain_x100[cur_reg.global_gain_code];
  end

  group_current_scale #(.cur_w(cur_w)) u_red
  (
    .pclk                (pclk),
    .presetn             (presetn),
    .max_channel_current (max_cur_reg),
    .level               (cur_reg.red_group_level),
    .group_current       (red_current)
  );

  group_current_scale #(.cur_w(cur_w)) u_green
  (
    .pclk                (pclk),
    .presetn             (presetn),
    .max_channel_current (max_cur_reg),
    .level               (cur_reg.green_group_level),
    .group_current       (green_current)
  );

  group_current_scale #(.cur_w(cur_w)) u_blue
  (
    .pclk                (pclk),
    .presetn             (presetn),
    .max_channel_current (max_cur_reg),
    .level               (cur_reg.blue_group_level),
    .group_current       (blue_current)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read mux, unmapped reads zero

  wire [31:0] rd_lay  = {23'h0, lay_reg};
  wire [31:0] rd_gain = {29'h0, cur_reg.global_gain_code};
  wire [31:0] rd_red  = {24'h0, cur_reg.red_group_level};
  wire [31:0] rd_grn  = {24'h0, cur_reg.green_group_level};
  wire [31:0] rd_blu  = {24'h0, cur_reg.blue_group_level};
  wire [31:0] rd_scan = {23'h0, stack_line_active, own_turn, 1'b0, slot_reg, step_reg};
  wire [31:0] rd_cur  = {{(32-cur_w){1'b0}}, max_cur_reg};
  wire [31:0] rd_val  = hit_lay ? rd_lay : hit_gain ? rd_gain : hit_red ? rd_red :
                        hit_grn ? rd_grn : hit_blu ? rd_blu : hit_scan ? rd_scan :
                        hit_cur ? rd_cur : 32'h0;

  // Read data registered in setup so it is stable in access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (psel && !penable && !pwrite)
      prdata <= rd_val;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // Reset defaults and register writes
  a_reset_level: assert property (@(posedge pclk)
    $rose(presetn) |-> cur_reg.red_group_level == level_rst)
    else $error("level reset wrong");
  a_level_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && hit_red |=> cur_reg.red_group_level == $past(pwdata[level_w-1:0]))
    else $error("red level write lost");
  // Gain lags its code by one cycle; the edge out of reset still shows zero
  a_gain_map: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 ($stable(cur_reg.global_gain_code) && $past(presetn)) |->
    global_current_gain == gain_x100[cur_reg.global_gain_code])
    else $error("gain wrong");
  // Reversed scan walks down one switch per step, quiet cycle before it
  a_reverse_order: assert property (@(posedge pclk) disable iff (!presetn)
    (lay_reg.line_order_reverse && lay_reg.scan_enable && !stack_mode && line_step && !step_wrap
    && !(wr_en && hit_lay) && !$past(line_step) && !$past(wr_en && hit_lay))
    ##2 1 |-> line_switch == ($past(line_switch, 2) >> 1))
    else $error("reverse scan out of order");
  // Idle drive and scan bounds
  a_idle_switch: assert property (@(posedge pclk) disable iff (!presetn)
    !lay_reg.scan_enable |=> line_switch == '0) else $error("switch on when idle");
  a_step_limit: assert property (@(posedge pclk) disable iff (!presetn)
    step_reg <= last_step || $past(wr_en && hit_lay)) else $error("unused line scanned");
  a_slot_limit: assert property (@(posedge pclk) disable iff (!presetn)
    slot_reg <= last_slot || $past(wr_en && hit_lay)) else $error("slot out of stack");
  a_indep_own: assert property (@(posedge pclk) disable iff (!presetn)
    lay_reg.matrix_layout_select == lay_indep && lay_reg.scan_enable
    |=> stack_line_active) else $error("independent not active");
  // A new layout restarts the scan at the first line of the stack
  a_layout_restart: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && hit_lay |=> step_reg == '0 && slot_reg == '0) else $error("scan not restarted");
  // Group current stays within the maximum and reaches it at full code
  a_group_scale: assert property (@(posedge pclk) disable iff (!presetn)
    ##2 ($stable(max_cur_reg) && $stable(cur_reg.red_group_level)) |->
    red_current <= max_cur_reg
    && (cur_reg.red_group_level != '1 || red_current == max_cur_reg))
    else $error("group current out of range");

  // Main scenarios
  c_stack_two: cover property (@(posedge pclk) lay_reg.matrix_layout_select == lay_s2
    && slot_reg == 2'h1);
  c_stack_four: cover property (@(posedge pclk) lay_reg.matrix_layout_select == lay_s4b
    && slot_reg == 2'h3);
  c_reverse: cover property (@(posedge pclk) lay_reg.line_order_reverse && line_switch[0]);
  c_order_four: cover property (@(posedge pclk) lay_reg.matrix_layout_select == lay_s4b
    && lay_reg.stack_position == 2'h3 && stack_line_active);

endmodule

/* tb/matrix_line_timer.sv */
// Stand-in for the line timer and the LED rows behind the line switches
module matrix_line_timer
  import matrix_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // Bench side
  input  wire logic                     advance,
  input  wire logic                     clear_seen,
  output logic      [lines_per_dev-1:0] lines_seen,
  // Device side
  input  wire logic [lines_per_dev-1:0] line_switch,
  output logic                          line_step
);
  timeunit 1ns;
  timeprecision 1ps;

  // One step pulse per request; rows remember being lit, so unused ones show
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line_step  <= 1'b0;
      lines_seen <= '0;
    end
    else
    begin
      line_step  <= advance;
      lines_seen <= clear_seen ? '0 : (lines_seen | line_switch);
    end
  end
endmodule

/* tb/test_matrix_scan_and_current_config.sv */
module test_matrix_scan_and_current_config;
  timeunit 1ns;
  timeprecision 1ps;
  import matrix_cfg_pkg::*;

  typedef struct {logic [7:0] a; logic [31:0] d; int sel; logic [15:0] e;} row_s;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        line_step;
  logic        advance = 1'b0;
  logic        clear_seen = 1'b0;
  logic [15:0] lines_seen;
  logic [15:0] line_switch;
  logic        stack_line_active;
  logic [5:0]  global_line;
  logic [14:0] global_current_gain;
  logic [15:0] red_current;
  logic [15:0] green_current;
  logic [15:0] blue_current;
  logic [31:0] rdat;
  logic        rerr;
  int          num_errors = 0;
  int          tests_run = 0;
  row_s        rows [12];

  // 50 MHz clock
  always #10 pclk = ~pclk;

  matrix_scan_and_current_config #(.cur_w(16)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_step(line_step), .line_switch(line_switch), .stack_line_active(stack_line_active),
    .global_line(global_line), .global_current_gain(global_current_gain),
    .red_current(red_current), .green_current(green_current), .blue_current(blue_current));

  matrix_line_timer i_timer (
    .pclk(pclk), .presetn(presetn), .advance(advance), .clear_seen(clear_seen),
    .lines_seen(lines_seen), .line_switch(line_switch), .line_step(line_step));

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge pclk);
    end
    if (n == 50)
      num_errors++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] cfg(input logic [2:0] l, input logic rv, input logic [1:0] c);
    return {23'h0, l, rv, 2'h0, c, 1'b1};
  endfunction

  // Full scan cycle including the wrap back to the first line
  task automatic scan(input logic rv, input logic [1:0] c, input int st, input int dir,
                      input logic [15:0] mask);
    int n;
    n = 16 - c;
    apb(1'b1, layout_off, cfg(lay_indep, rv, c));
    clear_seen <= 1'b1;
    tick(1);
    clear_seen <= 1'b0;
    tick(3);
    for (int i = 0; i <= n; i++)
    begin
      check(line_switch, 32'(16'h1 << (st + dir * (i % n))));
      step_lines(1);
    end
    check(lines_seen, mask);
    $display("test line_order_reverse=%0b cut=%0d done", rv, c);
  endtask

  // Line steps spaced so each one settles before the next
  task automatic step_lines(input int n);
    repeat (n)
    begin
      advance <= 1'b1;
      tick(1);
      advance <= 1'b0;
      tick(4);
    end
  endtask

  // Watchdog, far beyond the few hundred cycles the run needs
  initial
  begin
    #400us;
    num_errors++;
    test_done();
  end

  initial
  begin
    rows = '{'{gain_off, 0, 0, 16'd2417}, '{gain_off, 1, 0, 16'd3057},
             '{gain_off, 2, 0, 16'd4949}, '{gain_off, 3, 0, 16'd8661},
             '{gain_off, 4, 0, 16'd10394}, '{gain_off, 5, 0, 16'd12992},
             '{gain_off, 6, 0, 16'd14848}, '{gain_off, 7, 0, 16'd17323},
             '{red_off, 8'h00, 1, 16'd16}, '{green_off, 8'hff, 2, 16'd4096},
             '{blue_off, 8'h7f, 3, 16'd2048}, '{red_off, 8'hfe, 1, 16'd4080}};
    tick(20);
    presetn <= 1'b1;
    // Reset values of the level and gain registers
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b0, red_off + 8'(4 * i), 32'h0);
      check(rdat, 32'h7f);
    end
    apb(1'b0, gain_off, 32'h0);
    check(rdat, 32'h0);
    apb(1'b1, current_off, 32'h1000);
    tick(3);
    check(red_current, 32'd2048);
    apb(1'b0, current_off, 32'h0);
    check(rdat, 32'h1000);
    $display("test reset values done");
    // Table of gain codes and level codes
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, rows[i].d);
      tick(3);
      case (rows[i].sel)
        0: check({1'b0, global_current_gain}, rows[i].e);
        1: check(red_current, rows[i].e);
        2: check(green_current, rows[i].e);
        default: check(blue_current, rows[i].e);
      endcase
    end
    check({green_current, blue_current}, {16'd4096, 16'd2048});
    $display("test current rows done");
    // Unmapped address refused, write dropped
    apb(1'b1, 8'h40, 32'h12);
    check(rerr, 1'b1);
    apb(1'b0, 8'h40, 32'h0);
    check(rerr, 1'b1);
    check(rdat, 32'h0);
    apb(1'b0, red_off, 32'h0);
    check(rerr, 1'b0);
    check(rdat, 32'hfe);
    $display("test unmapped done");
    // Every layout code is accepted
    for (int c = 0; c < 8; c++)
    begin
      apb(1'b1, layout_off, cfg(3'(c), 1'b0, 2'h0));
      apb(1'b0, layout_off, 32'h0);
      check(rdat, cfg(3'(c), 1'b0, 2'h0));
    end
    $display("test layout codes done");
    scan(1'b0, 2'h0, 0, 1, 16'hffff);
    scan(1'b0, 2'h2, 0, 1, 16'h3fff);
    scan(1'b1, 2'h2, 15, -1, 16'hfffc);
    // Two-device stack: first device owns lines 1 to 16 only
    apb(1'b1, layout_off, cfg(lay_s2, 1'b0, 2'h0));
    tick(3);
    check(stack_line_active, 1'b1);
    apb(1'b0, scan_off, 32'h0);
    check(rdat, 32'h180);
    step_lines(16);
    check({stack_line_active, global_line}, {1'b0, 6'h10});
    check(line_switch, 32'h0);
    // Four-device order one, four, two, three: device four scans second
    apb(1'b1, layout_off, {23'h0, lay_s4b, 1'b0, 2'h3, 2'h0, 1'b1});
    tick(3);
    check(stack_line_active, 1'b0);
    step_lines(16);
    check({stack_line_active, line_switch}, {1'b1, 16'h0001});
    $display("test stack done");
    // Reset in mid-run restores the defaults
    presetn <= 1'b0;
    tick(2);
    check({red_current, global_current_gain}, 31'h0);
    presetn <= 1'b1;
    apb(1'b0, red_off, 32'h0);
    check(rdat, 32'h7f);
    $display("test second reset done");
    test_done();
  end
endmodule
